/* File: ltac_bench.sv */
// self-checking bench for the lookup table access engine
`default_nettype none

module ltac_bench;
   timeunit 1ns;
   timeprecision 1ps;

   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic        wr = 1'b0;
   logic        rd = 1'b0;
   logic [15:0] addr = 16'h0;
   logic [3:0]  be = 4'hf;
   logic [31:0] wdata = 32'h0;
   logic [31:0] rdata;
   logic        busy;
   logic [31:0] v;
   int          errors = 0;
   int          n_checks = 0;

   always #20 clk = ~clk;

   // small table keeps the search short
   ltac_top #(.AW(4)) uut
   (
      .i_mclk      (clk),
      .i_rst_n     (rst_n),
      .i_reg_wr    (wr),
      .i_reg_rd    (rd),
      .i_reg_addr  (addr),
      .i_reg_be    (be),
      .i_reg_wdata (wdata),
      .o_reg_rdata (rdata),
      .o_busy      (busy)
   );

   // ------------------------------------------------------------
   // access tasks
   // ------------------------------------------------------------
   task automatic chk(input string name, input logic [31:0] e, input logic [31:0] got);
      n_checks++;
      if (got !== e)
      begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", name, e, got);
      end
   endtask

   task automatic wr_reg(input logic [15:0] a, input logic [31:0] d);
      @(negedge clk);
      addr = a;
      wdata = d;
      wr = 1'b1;
      @(negedge clk);
      wr = 1'b0;
   endtask

   task automatic rd_reg(input logic [15:0] a, output logic [31:0] d);
      @(negedge clk);
      addr = a;
      rd = 1'b1;
      @(negedge clk);
      rd = 1'b0;
      d = rdata;
   endtask

   task automatic rchk(input logic [15:0] a, input logic [31:0] e);
      rd_reg(a, v);
      chk($sformatf("register %h", a), e, v);
   endtask

   task automatic wait_idle();
      int k;
      k = 0;
      @(negedge clk);
      while (busy !== 1'b0 && k < 500)
      begin
         @(negedge clk);
         k++;
      end
      chk("busy", 32'h0, {31'h0, busy});
   endtask

   task automatic ent(input logic [31:0] a, b, c, d);
      wr_reg(16'h0420, a);
      wr_reg(16'h0424, b);
      wr_reg(16'h0428, c);
      wr_reg(16'h042c, d);
   endtask

   // lookup operation: lower index first, then control flags with go set
   task automatic lk(input logic [31:0] ctl, input logic [31:0] idx);
      wr_reg(16'h0414, idx);
      wr_reg(16'h0418, ctl | 32'h80);
      wait_idle();
   endtask

   task automatic sm(input logic [31:0] ctl);
      wr_reg(16'h041c, ctl | 32'h80);
      wait_idle();
   endtask

   task automatic poll_ready();
      int k;
      k = 0;
      do
      begin
         rd_reg(16'h0418, v);
         k++;
      end
      while (v[6] !== 1'b1 && k < 200);
      chk("ready flag", 32'h1, {31'h0, v[6]});
   endtask

   task automatic results();
      $display("checks %0d mismatches %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   // ------------------------------------------------------------
   // tests
   // ------------------------------------------------------------
   initial
   begin
      repeat (10) @(negedge clk);
      rst_n = 1'b1;
      for (int a = 16'h0410; a <= 16'h0430; a += 4)
         rchk(a[15:0], 32'h0);
      $display("test reset values done");

      // raw index fill, entries 3 and 9 valid; bits above the table width ignored
      for (int i = 0; i < 16; i++)
      begin
         ent((i == 3 || i == 9) ? {28'h8000000, i[3:0]} : i, 0, 0, 32'hc0de_0000 + i);
         lk(32'h5, 32'h0000_0f00 + i);
      end
      ent(0, 0, 0, 0);
      lk(32'h6, 32'h9);
      rchk(16'h0420, 32'h8000_0009);
      rchk(16'h042c, 32'hc0de_0009);
      rchk(16'h0418, 32'h6);
      lk(32'h4, 32'h3);
      rchk(16'h0420, 32'h8000_0009);
      rchk(16'h0418, 32'h4);
      $display("test raw write and read done");

      wr_reg(16'h0418, 32'h83);
      for (int j = 3; j <= 9; j += 6)
      begin
         poll_ready();
         rchk(16'h0420, 32'h8000_0000 + j);
         rchk(16'h042c, 32'hc0de_0000 + j);
      end
      wait_idle();
      rchk(16'h0418, 32'h0002_0023);
      $display("test search done");

      wr_reg(16'h0410, 32'h0012_abcd);
      ent(32'h5555, 0, 0, 0);
      lk(32'h1, 32'h1122_3344);
      ent(0, 0, 0, 0);
      lk(32'h2, 32'h1122_3344);
      rchk(16'h0420, 32'h5555);
      wr_reg(16'h0410, 32'h0013_abcd);
      rchk(16'h0410, 32'h0013_abcd);
      lk(32'h2, 32'h1122_3344);
      rd_reg(16'h0420, v);
      chk("other key hit", 32'h0, {31'h0, v === 32'h5555});
      $display("test hashed access done");

      ent(32'h1111_1111, 32'h2222_2222, 32'h3333_3333, 32'h4444_4444);
      sm(32'h0005_0000);
      ent(0, 32'haa, 0, 0);
      sm(32'h0005_0002);
      ent(0, 32'hbb, 0, 0);
      sm(32'h0025_0002);
      ent(32'h7, 0, 0, 0);
      sm(32'h0005_0003);
      rchk(16'h0424, 32'haa);
      rchk(16'h0420, 32'h7);
      sm(32'h0025_0003);
      rchk(16'h0424, 32'hbb);
      sm(32'h0015_0001);
      for (int k = 0; k < 4; k++)
         rchk(16'h0420 + 4 * k, 32'h1111_1111 * (k + 1));
      rchk(16'h041c, 32'h0015_0001);
      $display("test static and multicast done");
      results();
   end

   initial
   begin
      #2000000;
      errors++;
      $display("[FAIL] watchdog expected finish seen timeout");
      results();
   end

endmodule // ltac_bench

`default_nettype wire

/* File: ltac_defines.vh */
// register offsets, field positions and state codes of the lookup table access engine
`ifndef LTAC_DEFINES_VH
`define LTAC_DEFINES_VH

// ------------------------------------------------------------
// register byte offsets
// ------------------------------------------------------------
`define LTAC_OFF_INDEX_HI     16'h0410
`define LTAC_OFF_INDEX_LO     16'h0414
`define LTAC_OFF_LOOKUP_CTL   16'h0418
`define LTAC_OFF_STMC_CTL     16'h041c
`define LTAC_OFF_ENTRY_ONE    16'h0420
`define LTAC_OFF_ENTRY_TWO    16'h0424
`define LTAC_OFF_ENTRY_THREE  16'h0428
`define LTAC_OFF_ENTRY_FOUR   16'h042c
// byte lane of entry word four that holds byte 0x042f
`define LTAC_ENTRY_FOUR_TOP_BE 3

// ------------------------------------------------------------
// lookup control fields
// ------------------------------------------------------------
`define LTAC_LK_OP_HI         1
`define LTAC_LK_OP_LO         0
`define LTAC_LK_RAW_BIT       2
`define LTAC_LK_RSV_HI        4
`define LTAC_LK_RSV_LO        3
`define LTAC_LK_COMBO_BIT     5
`define LTAC_LK_READY_BIT     6
`define LTAC_GO_DONE_BIT      7
`define LTAC_LK_CNT_HI        29
`define LTAC_LK_CNT_LO        16
`define LTAC_CNT_W            14

`define LTAC_OP_NOP           2'h0
`define LTAC_OP_WRITE         2'h1
`define LTAC_OP_READ          2'h2
`define LTAC_OP_SEARCH        2'h3

// ------------------------------------------------------------
// static / reserved multicast control fields
// ------------------------------------------------------------
`define LTAC_SM_DIR_BIT       0
`define LTAC_SM_SEL_BIT       1
`define LTAC_SM_RSV_HI        6
`define LTAC_SM_RSV_LO        2
`define LTAC_SM_IDX_HI        21
`define LTAC_SM_IDX_LO        16
`define LTAC_SM_IDX_W         6
`define LTAC_ST_IDX_W         4

// ------------------------------------------------------------
// index register fields
// ------------------------------------------------------------
`define LTAC_FLT_ID_HI        22
`define LTAC_FLT_ID_LO        16
`define LTAC_FLT_ID_W         7
`define LTAC_MAC_HI_HI        15
`define LTAC_MAC_HI_LO        0
`define LTAC_RAW_IDX_HI       11

// entry valid marker inside entry word one
`define LTAC_ENTRY_VALID_BIT  31

// ------------------------------------------------------------
// engine states
// ------------------------------------------------------------
`define LTAC_ST_IDLE          3'h0
`define LTAC_ST_LK_DONE       3'h1
`define LTAC_ST_SCAN          3'h2
`define LTAC_ST_HOLD          3'h3
`define LTAC_ST_SM_DONE       3'h4

`endif

/* File: ltac_hash.v */
// hash of filter identifier and station address into a lookup table location
`default_nettype none

module ltac_hash
#(
   parameter AW = 12
)
(
   // key
   input  wire [6:0]    i_filter_id,
   input  wire [47:0]   i_mac,
   // location
   output reg  [AW-1:0] o_loc
);

   reg [54:0] key;
   integer    k;

   // xor fold of the 55-bit key down to AW bits
   always @*
   begin
      key   = {i_filter_id, i_mac};
      o_loc = {AW{1'b0}};
      for (k = 0; k < 55; k = k + 1)
      begin
         o_loc[k % AW] = o_loc[k % AW] ^ key[k];
      end
   end

endmodule // ltac_hash

`default_nettype wire

/* File: ltac_top.v */
// register bank and access engine for the switch forwarding tables
//
// What this block does
// - writing one to the lookup go bit starts the operation; engine clears it after
// - lookup operation code: 00 none, 01 write, 10 read, 11 search
// - search sets ready flag per valid entry; reading byte 0x042f clears it
// - after search the fourteen-bit count field shows valid entry total
// - combined flag reads one when ready flag set or search ended
// - raw-index bit one addresses table directly; zero uses the hash
// - reserved multicast table is addressed by all six index bits
// - static table uses only the low four index bits
// - static table go bit starts the access and clears when finished
// - table select one picks reserved multicast, zero picks static table
// - static control direction bit: one reads, zero writes
// - multicast uses entry word two only; static uses entry words one to four
// - lookup key comes from index registers; data through four entry registers
// - raw-index uses low twelve bits of lower index; else hash address and filter id
// - upper index holds seven-bit filter identifier and top sixteen address bits
`default_nettype none
`include "ltac_defines.vh"

module ltac_top
#(
   parameter AW      = 12,
   parameter ST_SIZE = 16,
   parameter MC_SIZE = 64
)
(
   // clock and reset
   input  wire        i_mclk,
   input  wire        i_rst_n,
   // register port from the management interface logic
   input  wire        i_reg_wr,
   input  wire        i_reg_rd,
   input  wire [15:0] i_reg_addr,
   input  wire [3:0]  i_reg_be,
   input  wire [31:0] i_reg_wdata,
   // register read data, one cycle after the read strobe
   output reg  [31:0] o_reg_rdata,
   // engine status
   output wire        o_busy
);

   localparam DEPTH = 1 << AW;
   // ------------------------------------------------------------
   // table storage
   // ------------------------------------------------------------
   reg [127:0] lut_mem [0:DEPTH-1];
   reg [127:0] st_mem  [0:ST_SIZE-1];
   reg [31:0]  mc_mem  [0:MC_SIZE-1];

   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   reg [31:0]             index_hi_q;
   reg [31:0]             index_lo_q;
   reg [1:0]              lk_op_q;
   reg                    lk_raw_q;
   reg [1:0]              lk_rsv_q;
   reg                    lk_go_q;
   reg                    lk_ready_q;
   reg                    lk_end_q;
   reg [`LTAC_CNT_W-1:0]  lk_cnt_q;
   reg [`LTAC_CNT_W-1:0]  scan_cnt_q;
   reg [`LTAC_SM_IDX_W-1:0] sm_idx_q;
   reg                    sm_dir_q;
   reg                    sm_sel_q;
   reg [4:0]              sm_rsv_q;
   reg                    sm_go_q;
   reg [31:0]             entry_q [0:3];
   reg [2:0]              state_q;
   reg [AW-1:0]           scan_idx_q;

   // ------------------------------------------------------------
   // address decode
   // ------------------------------------------------------------
   wire hit_ihi = (i_reg_addr == `LTAC_OFF_INDEX_HI);
   wire hit_ilo = (i_reg_addr == `LTAC_OFF_INDEX_LO);
   wire hit_lk  = (i_reg_addr == `LTAC_OFF_LOOKUP_CTL);
   wire hit_sm  = (i_reg_addr == `LTAC_OFF_STMC_CTL);
   wire hit_e1  = (i_reg_addr == `LTAC_OFF_ENTRY_ONE);
   wire hit_e2  = (i_reg_addr == `LTAC_OFF_ENTRY_TWO);
   wire hit_e3  = (i_reg_addr == `LTAC_OFF_ENTRY_THREE);
   wire hit_e4  = (i_reg_addr == `LTAC_OFF_ENTRY_FOUR);

   wire idle    = (state_q == `LTAC_ST_IDLE) && !lk_go_q && !sm_go_q;
   assign o_busy = !idle;
   // reading the top byte of entry word four releases the search
   wire ready_clr = i_reg_rd && hit_e4 && i_reg_be[`LTAC_ENTRY_FOUR_TOP_BE];
   // byte-lane merge of write data
   function [31:0] merge;
      input [31:0] old;
      input [31:0] nw;
      input [3:0]  be;
      integer      b;
      begin
         merge = old;
         for (b = 0; b < 4; b = b + 1)
         begin
            if (be[b])
               merge[b*8 +: 8] = nw[b*8 +: 8];
         end
      end
   endfunction
   wire [31:0] lk_view = {2'h0, lk_cnt_q, 8'h00, lk_go_q, lk_ready_q,
                          lk_ready_q | lk_end_q, lk_rsv_q, lk_raw_q, lk_op_q};
   wire [31:0] sm_view = {10'h000, sm_idx_q, 8'h00, sm_go_q, sm_rsv_q, sm_sel_q, sm_dir_q};
   wire [31:0] lk_wr   = merge(lk_view, i_reg_wdata, i_reg_be);
   wire [31:0] sm_wr   = merge(sm_view, i_reg_wdata, i_reg_be);
   // ------------------------------------------------------------
   // lookup location
   // ------------------------------------------------------------
   wire [AW-1:0] hash_loc;
   ltac_hash #(
      .AW    (AW)
   ) u_hash (
      .i_filter_id (index_hi_q[`LTAC_FLT_ID_HI:`LTAC_FLT_ID_LO]),
      .i_mac       ({index_hi_q[`LTAC_MAC_HI_HI:`LTAC_MAC_HI_LO], index_lo_q}),
      .o_loc       (hash_loc)
   );
   wire [AW-1:0] raw_loc = index_lo_q[AW-1:0];
   wire [AW-1:0] lut_loc = lk_raw_q ? raw_loc : hash_loc;
   wire [AW-1:0] last_idx = {AW{1'b1}};
   wire [127:0]  scan_word = lut_mem[scan_idx_q];
   wire          scan_hit  = scan_word[`LTAC_ENTRY_VALID_BIT];
   wire [`LTAC_ST_IDX_W-1:0] st_loc = sm_idx_q[`LTAC_ST_IDX_W-1:0];
   wire [`LTAC_SM_IDX_W-1:0] mc_loc = sm_idx_q;
   wire [127:0] entry_cat = {entry_q[3], entry_q[2], entry_q[1], entry_q[0]};

   // ------------------------------------------------------------
   // table writes
   // ------------------------------------------------------------
   always @(posedge i_mclk)
   begin
      if (state_q == `LTAC_ST_IDLE && lk_go_q && lk_op_q == `LTAC_OP_WRITE)
         lut_mem[lut_loc] <= entry_cat;
      if (state_q == `LTAC_ST_IDLE && !lk_go_q && sm_go_q && !sm_dir_q)
      begin
         if (sm_sel_q)
            mc_mem[mc_loc] <= entry_q[1];
         else
            st_mem[st_loc] <= entry_cat;
      end
   end

   // ------------------------------------------------------------
   // registers and engine
   // ------------------------------------------------------------
   integer e;
   always @(posedge i_mclk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         index_hi_q <= 32'h0000_0000;
         index_lo_q <= 32'h0000_0000;
         lk_op_q    <= `LTAC_OP_NOP;
         lk_raw_q   <= 1'b0;
         lk_rsv_q   <= 2'h0;
         lk_go_q    <= 1'b0;
         lk_ready_q <= 1'b0;
         lk_end_q   <= 1'b0;
         lk_cnt_q   <= {`LTAC_CNT_W{1'b0}};
         scan_cnt_q <= {`LTAC_CNT_W{1'b0}};
         sm_idx_q   <= {`LTAC_SM_IDX_W{1'b0}};
         sm_dir_q   <= 1'b0;
         sm_sel_q   <= 1'b0;
         sm_rsv_q   <= 5'h00;
         sm_go_q    <= 1'b0;
         state_q    <= `LTAC_ST_IDLE;
         scan_idx_q <= {AW{1'b0}};
         for (e = 0; e < 4; e = e + 1)
            entry_q[e] <= 32'h0000_0000;
      end
      else
      begin
         // software writes take effect only while the engine is idle
         if (i_reg_wr && idle)
         begin
            if (hit_ihi)
               index_hi_q <= merge(index_hi_q, i_reg_wdata, i_reg_be);
            else if (hit_ilo)
               index_lo_q <= merge(index_lo_q, i_reg_wdata, i_reg_be);
            else if (hit_lk)
            begin
               lk_op_q  <= lk_wr[`LTAC_LK_OP_HI:`LTAC_LK_OP_LO];
               lk_raw_q <= lk_wr[`LTAC_LK_RAW_BIT];
               lk_rsv_q <= lk_wr[`LTAC_LK_RSV_HI:`LTAC_LK_RSV_LO];
               lk_go_q  <= lk_wr[`LTAC_GO_DONE_BIT];
               if (lk_wr[`LTAC_GO_DONE_BIT])
                  lk_end_q <= 1'b0;
            end
            else if (hit_sm)
            begin
               sm_dir_q <= sm_wr[`LTAC_SM_DIR_BIT];
               sm_sel_q <= sm_wr[`LTAC_SM_SEL_BIT];
               sm_rsv_q <= sm_wr[`LTAC_SM_RSV_HI:`LTAC_SM_RSV_LO];
               sm_idx_q <= sm_wr[`LTAC_SM_IDX_HI:`LTAC_SM_IDX_LO];
               sm_go_q  <= sm_wr[`LTAC_GO_DONE_BIT];
            end
            else if (hit_e1)
               entry_q[0] <= merge(entry_q[0], i_reg_wdata, i_reg_be);
            else if (hit_e2)
               entry_q[1] <= merge(entry_q[1], i_reg_wdata, i_reg_be);
            else if (hit_e3)
               entry_q[2] <= merge(entry_q[2], i_reg_wdata, i_reg_be);
            else if (hit_e4)
               entry_q[3] <= merge(entry_q[3], i_reg_wdata, i_reg_be);
         end
         if (ready_clr)
            lk_ready_q <= 1'b0;
         case (state_q)
            `LTAC_ST_IDLE:
            begin
               if (lk_go_q)
               begin
                  case (lk_op_q)
                     `LTAC_OP_READ:
                     begin
                        for (e = 0; e < 4; e = e + 1)
                           entry_q[e] <= lut_mem[lut_loc][e*32 +: 32];
                        state_q <= `LTAC_ST_LK_DONE;
                     end
                     `LTAC_OP_SEARCH:
                     begin
                        scan_idx_q <= {AW{1'b0}};
                        scan_cnt_q <= {`LTAC_CNT_W{1'b0}};
                        lk_ready_q <= 1'b0;
                        state_q    <= `LTAC_ST_SCAN;
                     end
                     default:
                        state_q <= `LTAC_ST_LK_DONE;
                  endcase
               end
               else if (sm_go_q)
               begin
                  if (sm_dir_q)
                  begin
                     if (sm_sel_q)
                        entry_q[1] <= mc_mem[mc_loc];
                     else
                        for (e = 0; e < 4; e = e + 1)
                           entry_q[e] <= st_mem[st_loc][e*32 +: 32];
                  end
                  state_q <= `LTAC_ST_SM_DONE;
               end
            end
            `LTAC_ST_LK_DONE:
            begin
               lk_go_q <= 1'b0;
               state_q <= `LTAC_ST_IDLE;
            end
            `LTAC_ST_SM_DONE:
            begin
               sm_go_q <= 1'b0;
               state_q <= `LTAC_ST_IDLE;
            end
            `LTAC_ST_SCAN:
            begin
               if (scan_hit)
               begin
                  for (e = 0; e < 4; e = e + 1)
                     entry_q[e] <= scan_word[e*32 +: 32];
                  scan_cnt_q <= scan_cnt_q + 1'b1;
                  lk_ready_q <= 1'b1;
                  state_q    <= `LTAC_ST_HOLD;
               end
               else if (scan_idx_q == last_idx)
               begin
                  lk_cnt_q <= scan_cnt_q;
                  lk_end_q <= 1'b1;
                  lk_go_q  <= 1'b0;
                  state_q  <= `LTAC_ST_IDLE;
               end
               else
                  scan_idx_q <= scan_idx_q + 1'b1;
            end
            `LTAC_ST_HOLD:
            begin
               // wait for software to take the entry before moving on
               if (!lk_ready_q)
               begin
                  if (scan_idx_q == last_idx)
                  begin
                     lk_cnt_q <= scan_cnt_q;
                     lk_end_q <= 1'b1;
                     lk_go_q  <= 1'b0;
                     state_q  <= `LTAC_ST_IDLE;
                  end
                  else
                  begin
                     scan_idx_q <= scan_idx_q + 1'b1;
                     state_q    <= `LTAC_ST_SCAN;
                  end
               end
            end
            default:
               state_q <= `LTAC_ST_IDLE;
         endcase
      end
   end

   // ------------------------------------------------------------
   // read data
   // ------------------------------------------------------------
   always @(posedge i_mclk or negedge i_rst_n)
   begin
      if (!i_rst_n)
         o_reg_rdata <= 32'h0000_0000;
      else if (i_reg_rd)
      begin
         if (hit_ihi)
            o_reg_rdata <= {9'h000, index_hi_q[`LTAC_FLT_ID_HI:0]};
         else if (hit_ilo)
            o_reg_rdata <= index_lo_q;
         else if (hit_lk)
            o_reg_rdata <= lk_view;
         else if (hit_sm)
            o_reg_rdata <= sm_view;
         else if (hit_e1)
            o_reg_rdata <= entry_q[0];
         else if (hit_e2)
            o_reg_rdata <= entry_q[1];
         else if (hit_e3)
            o_reg_rdata <= entry_q[2];
         else if (hit_e4)
            o_reg_rdata <= entry_q[3];
         else
            o_reg_rdata <= 32'h0000_0000;
      end
   end

endmodule // ltac_top

`default_nettype wire

/* File: ltac_top_assertions.sv */
// concurrent checks on the register port of the lookup table access engine
`default_nettype none

module ltac_top_assertions
#(
   parameter AW      = 12,
   parameter ST_SIZE = 16,
   parameter MC_SIZE = 64
)
(
   // clock and reset
   input wire logic        i_mclk,
   input wire logic        i_rst_n,
   // register port
   input wire logic        i_reg_wr,
   input wire logic        i_reg_rd,
   input wire logic [15:0] i_reg_addr,
   input wire logic [3:0]  i_reg_be,
   input wire logic [31:0] i_reg_wdata,
   input wire logic [31:0] o_reg_rdata,
   input wire logic        o_busy
);
   timeunit 1ns;
   timeprecision 1ps;

   default clocking cb @(posedge i_mclk);
   endclocking
   default disable iff (!i_rst_n);

   // a go bit written while the engine is free
   wire go_wr = i_reg_wr && !o_busy && i_reg_be[0] && i_reg_wdata[7];

   // ------------------------------------------------------------
   // sequences
   // ------------------------------------------------------------
   sequence lk_go_s;
      go_wr && i_reg_addr == 16'h0418;
   endsequence
   sequence sm_go_s;
      go_wr && i_reg_addr == 16'h041c;
   endsequence
   sequence settle_s;
      o_busy ##[1:3] !o_busy;
   endsequence
   sequence rd_at(logic [15:0] a);
      i_reg_rd && i_reg_addr == a;
   endsequence

   // ------------------------------------------------------------
   // properties
   // ------------------------------------------------------------
   lk_finish_a: assert property (lk_go_s ##0 (i_reg_wdata[1:0] != 2'h3) |=> settle_s)
      else $error("lookup access did not finish in time");
   scan_busy_a: assert property (lk_go_s ##0 (i_reg_wdata[1:0] == 2'h3) |=> o_busy[*4])
      else $error("search ended too early");
   sm_finish_a: assert property (sm_go_s |=> settle_s)
      else $error("static access did not finish in time");
   lk_go_clear_a: assert property (rd_at(16'h0418) ##0 !o_busy |=> !o_reg_rdata[7])
      else $error("lookup go bit read set while idle");
   sm_go_clear_a: assert property (rd_at(16'h041c) ##0 !o_busy |=> !o_reg_rdata[7])
      else $error("static go bit read set while idle");
   lk_rsv_zero_a: assert property (rd_at(16'h0418) |=>
      o_reg_rdata[31:30] == 2'h0 && o_reg_rdata[15:8] == 8'h0)
      else $error("lookup control reserved bits not zero");
   sm_rsv_zero_a: assert property (rd_at(16'h041c) |=>
      o_reg_rdata[31:22] == 10'h0 && o_reg_rdata[15:8] == 8'h0)
      else $error("static control reserved bits not zero");
   combo_flag_a: assert property (rd_at(16'h0418) |=> !o_reg_rdata[6] || o_reg_rdata[5])
      else $error("combined flag low while ready flag set");
   unmapped_zero_a: assert property (i_reg_rd && (i_reg_addr < 16'h0410 ||
      i_reg_addr > 16'h042c) |=> o_reg_rdata == 32'h0)
      else $error("unmapped read not zero");
   rdata_hold_a: assert property (!i_reg_rd |=> $stable(o_reg_rdata))
      else $error("read data changed without a read");

endmodule // ltac_top_assertions

bind ltac_top ltac_top_assertions #(.AW(AW), .ST_SIZE(ST_SIZE), .MC_SIZE(MC_SIZE)) u_chk
(
   .i_mclk      (i_mclk),
   .i_rst_n     (i_rst_n),
   .i_reg_wr    (i_reg_wr),
   .i_reg_rd    (i_reg_rd),
   .i_reg_addr  (i_reg_addr),
   .i_reg_be    (i_reg_be),
   .i_reg_wdata (i_reg_wdata),
   .o_reg_rdata (o_reg_rdata),
   .o_busy      (o_busy)
);

`default_nettype wire
